// ### design/rmon_stats_counters.sv
// rmon_stats_counters: bank of four statistics counters with a simple
// memory-window register port.
// assumes: frame events come from MAC logic on clk_i; the enable and mask
// bits come from the control registers kept elsewhere in the controller.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - tx_octet_count adds the octets of every transmitted frame.
// - octet and length figures add back the four VLAN tag octets when the MAC inserted or stripped a tag.
// - reaching 0xc000 pulses stats_refresh_event for the interrupt flag register.
// - count only when global enable is 1 and own mask bit is 0.
// - rx_packet_count counts every received packet that passes the filter, bad, broadcast, multicast too.
// - rx_packet_count only counts frames the receive filter mode lets through.
// - rx_len64_count counts received packets exactly 64 octets long.
// - rx_len65_127_count counts received packets 65 to 127 octets inclusive.
// - length excludes preamble and framing, includes the FCS octets.
// - registers answer memory-window accesses only, never I/O space.
module rmon_stats_counters
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic        reg_req_i,
  input  wire logic        reg_io_space_i,
  input  wire logic        reg_wr_i,
  input  wire logic [8:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic             reg_ack_o,
  output logic [31:0]      reg_rdata_o,
  // control bits
  input  wire logic        stats_global_enable_i,
  input  wire logic [3:0]  rmon_counter_mask_i,
  // transmit side
  input  wire logic        tx_frame_done_i,
  input  wire logic [15:0] tx_frame_len_i,
  input  wire logic        tx_tag_inserted_i,
  // receive side
  input  wire logic        rx_frame_done_i,
  input  wire logic [15:0] rx_frame_len_i,
  input  wire logic        rx_tag_stripped_i,
  input  wire logic        rx_filter_pass_i,
  // event
  output logic             stats_refresh_event_o
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] decode_ofs(input logic [8:0] addr);
    // bit 2 flags a hit, bits 1:0 the counter index
    case (addr)
      rmon_stats_pkg::TX_OCTET_COUNT_OFS:
        decode_ofs = {1'b1, rmon_stats_pkg::IDX_TX_OCTET};
      rmon_stats_pkg::RX_PACKET_COUNT_OFS:
        decode_ofs = {1'b1, rmon_stats_pkg::IDX_RX_PKT};
      rmon_stats_pkg::RX_LEN64_COUNT_OFS:
        decode_ofs = {1'b1, rmon_stats_pkg::IDX_LEN64};
      rmon_stats_pkg::RX_LEN65_127_COUNT_OFS:
        decode_ofs = {1'b1, rmon_stats_pkg::IDX_LEN65};
      default:
        decode_ofs = 3'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // length helpers
  // ----------------------------------------------------------------
  // the MAC reports a length that lacks any tag it inserted or stripped;
  // the statistics always count the four tag octets, so they go back in
  function automatic logic [15:0] tagged_len
  (
    input logic [15:0] len,
    input logic        tag_gone
  );
    logic [16:0] sum;
    sum = {1'b0, len};
    if (tag_gone)
    begin
      sum = sum + {1'b0, rmon_stats_pkg::VLAN_TAG_LEN};
    end
    // jumbo frames stay far below the 16-bit limit, so the carry is cut
    tagged_len = sum[15:0];
  endfunction

  // inclusive length window, shared by both length bins
  function automatic logic len_in_bin
  (
    input logic [15:0] len,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    len_in_bin = (len >= lo) && (len <= hi);
  endfunction

  typedef struct packed
  {
    logic        ack;
    logic [31:0] rdata;
    logic        refresh;
  } bank_state_t;

  bank_state_t state_ff;
  bank_state_t nxt_state;

  stat_ctr_if ctr_bus [rmon_stats_pkg::NUM_CTR] ();

  logic [rmon_stats_pkg::NUM_CTR-1:0] ctr_event;
  logic [rmon_stats_pkg::NUM_CTR-1:0] ctr_hit;
  logic [31:0]                        ctr_amount [rmon_stats_pkg::NUM_CTR];
  logic [31:0]                        ctr_value  [rmon_stats_pkg::NUM_CTR];
  logic [15:0]                        tx_len_full;
  logic [15:0]                        rx_len_full;
  logic                               mem_access;
  logic [2:0]                         wr_dec;
  logic [2:0]                         rd_dec;
  logic [rmon_stats_pkg::NUM_CTR-1:0] wr_sel;

  // ----------------------------------------------------------------
  // frame length and per-counter events
  // ----------------------------------------------------------------
  // the tag octets are added back when the MAC inserts or strips it,
  // so the figure matches what the frame carries with its tag
  assign tx_len_full = tagged_len(tx_frame_len_i, tx_tag_inserted_i);
  // rx length is already from destination address through FCS
  assign rx_len_full = tagged_len(rx_frame_len_i, rx_tag_stripped_i);

  always_comb
  begin
    ctr_event = '0;
    ctr_event[rmon_stats_pkg::IDX_TX_OCTET] = tx_frame_done_i;
    ctr_event[rmon_stats_pkg::IDX_RX_PKT]   = rx_frame_done_i && rx_filter_pass_i;
    // length bins count every frame, good or bad, filtered or not
    ctr_event[rmon_stats_pkg::IDX_LEN64]    = rx_frame_done_i && len_in_bin(rx_len_full,
      rmon_stats_pkg::LEN_BIN64, rmon_stats_pkg::LEN_BIN64);
    ctr_event[rmon_stats_pkg::IDX_LEN65]    = rx_frame_done_i && len_in_bin(rx_len_full,
      rmon_stats_pkg::LEN_BIN65, rmon_stats_pkg::LEN_BIN127);
  end

  always_comb
  begin
    ctr_amount = '{default: rmon_stats_pkg::ONE};
    ctr_amount[rmon_stats_pkg::IDX_TX_OCTET] = {16'h0000, tx_len_full};
  end

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  // I/O-space cycles are decoded too, but mem_access keeps them from the strobes and the answer
  assign mem_access = reg_req_i && !reg_io_space_i;
  assign wr_dec     = decode_ofs(reg_addr_i);
  assign rd_dec     = decode_ofs(reg_addr_i);

  // one-hot load strobes; a write to an unmapped offset selects nothing
  // and is dropped, while the answer below still acknowledges it
  always_comb
  begin
    wr_sel = '0;
    if (mem_access && reg_wr_i && wr_dec[2])
    begin
      wr_sel[wr_dec[1:0]] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // counter cells
  // ----------------------------------------------------------------

  genvar gi;
  generate
    for (gi = 0; gi < rmon_stats_pkg::NUM_CTR; gi++)
    begin : g_ctr
      assign ctr_bus[gi].en         = ctr_event[gi] && stats_global_enable_i &&
                                      !rmon_counter_mask_i[gi];
      assign ctr_bus[gi].amount     = ctr_amount[gi];
      // en and load may rise together; the cell lets the write win
      assign ctr_bus[gi].load       = wr_sel[gi];
      assign ctr_bus[gi].load_value = reg_wdata_i;
      assign ctr_value[gi]          = ctr_bus[gi].count;
      assign ctr_hit[gi]            = ctr_bus[gi].hit;

      stat_counter u_ctr
      (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .bus     (ctr_bus[gi].ctr)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // register answer and event
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state         = state_ff;
    // answer one cycle after the taking edge, mapped offset or not
    nxt_state.ack     = mem_access;
    nxt_state.refresh = |ctr_hit;
    if (mem_access && !reg_wr_i)
    begin
      // unmapped offsets read as zero rather than stalling the host
      nxt_state.rdata = rd_dec[2] ? ctr_value[rd_dec[1:0]] : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= '{ack: 1'b0, rdata: 32'h0000_0000, refresh: 1'b0};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign reg_ack_o             = state_ff.ack;
  assign reg_rdata_o           = state_ff.rdata;
  assign stats_refresh_event_o = state_ff.refresh;

endmodule
`default_nettype wire

// ### design/rmon_stats_pkg.sv
// rmon_stats_pkg: offsets, indices, reset values and thresholds of the
// statistics counter bank.
// assumes: shared by the bank top and its counter cells.
package rmon_stats_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses in the memory window)
  // ----------------------------------------------------------------
  localparam logic [8:0]  TX_OCTET_COUNT_OFS     = 9'h104;
  localparam logic [8:0]  RX_LEN64_COUNT_OFS     = 9'h13c;
  localparam logic [8:0]  RX_LEN65_127_COUNT_OFS = 9'h140;
  localparam logic [8:0]  RX_PACKET_COUNT_OFS    = 9'h108;

  // ----------------------------------------------------------------
  // counter indices, also the bit positions of the mask input
  // ----------------------------------------------------------------
  localparam int          NUM_CTR      = 4;
  localparam logic [1:0]  IDX_TX_OCTET = 2'h0;
  localparam logic [1:0]  IDX_RX_PKT   = 2'h1;
  localparam logic [1:0]  IDX_LEN64    = 2'h2;
  localparam logic [1:0]  IDX_LEN65    = 2'h3;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTR_RESET     = 32'h0000_0000;
  localparam logic [31:0] CTR_THRESHOLD = 32'h0000_c000;
  localparam logic [15:0] VLAN_TAG_LEN  = 16'h0004;
  localparam logic [15:0] LEN_BIN64     = 16'h0040;
  localparam logic [15:0] LEN_BIN65     = 16'h0041;
  localparam logic [15:0] LEN_BIN127    = 16'h007f;
  localparam logic [31:0] ONE           = 32'h0000_0001;

endpackage

// ### design/stat_counter.sv
// stat_counter: one 32-bit wrapping statistics counter with threshold hit.
// assumes: bank drives en/amount/load from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module stat_counter
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  stat_ctr_if.ctr   bus
);

  typedef struct packed
  {
    logic [31:0] count;
    logic        hit;
  } ctr_state_t;

  ctr_state_t state_ff;
  ctr_state_t nxt_state;

  always_comb
  begin
    nxt_state     = state_ff;
    nxt_state.hit = 1'b0;
    if (bus.load)
    begin
      // a software write beats a count arriving in the same cycle
      nxt_state.count = bus.load_value;
    end
    else if (bus.en)
    begin
      // plain 32-bit add wraps to zero past the top
      nxt_state.count = state_ff.count + bus.amount;
      // pulse only on arrival at the threshold, not while parked there
      nxt_state.hit   = (nxt_state.count == rmon_stats_pkg::CTR_THRESHOLD) &&
                        (state_ff.count != rmon_stats_pkg::CTR_THRESHOLD);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= '{count: rmon_stats_pkg::CTR_RESET, hit: 1'b0};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign bus.count = state_ff.count;
  assign bus.hit   = state_ff.hit;

endmodule
`default_nettype wire

// ### design/stat_ctr_if.sv
// stat_ctr_if: control and result lines between the bank and one counter.
// assumes: one clock domain; driven by the bank, answered by the cell.
`timescale 1ns/100ps
`default_nettype none
interface stat_ctr_if;
  logic        en;
  logic [31:0] amount;
  logic        load;
  logic [31:0] load_value;
  logic [31:0] count;
  logic        hit;

  modport bank
  (
    output en,
    output amount,
    output load,
    output load_value,
    input  count,
    input  hit
  );

  modport ctr
  (
    input  en,
    input  amount,
    input  load,
    input  load_value,
    output count,
    output hit
  );
endinterface
`default_nettype wire

// ### verification/rmon_stats_counters_tb.sv
// rmon_stats_counters_tb: directed self-checking bench of the counter bank.
// assumes: bench acts as host register master and as the MAC event source.
`timescale 1ns/100ps
`default_nettype none
module rmon_stats_counters_tb;
  localparam logic [8:0] TXO = rmon_stats_pkg::TX_OCTET_COUNT_OFS;
  localparam logic [8:0] PKO = rmon_stats_pkg::RX_PACKET_COUNT_OFS;
  localparam logic [8:0] L64 = rmon_stats_pkg::RX_LEN64_COUNT_OFS;
  localparam logic [8:0] L65 = rmon_stats_pkg::RX_LEN65_127_COUNT_OFS;
  logic clk_i = 0, rst_n_i = 0, req = 0, io = 0, wr = 0, gen = 0, ack, ev;
  logic txd = 0, txt = 0, rxd = 0, rxs = 0, rxp = 0;
  logic [8:0] addr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic [3:0] mask = '0;
  logic [15:0] ln = '0;
  logic k, e;
  int n_errors = 0, comparisons = 0;
  always #2.5 clk_i = ~clk_i;
  rmon_stats_counters dut_u (.clk_i, .rst_n_i, .reg_req_i(req), .reg_io_space_i(io),
    .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_ack_o(ack),
    .reg_rdata_o(rdata), .stats_global_enable_i(gen), .rmon_counter_mask_i(mask),
    .tx_frame_done_i(txd), .tx_frame_len_i(ln), .tx_tag_inserted_i(txt),
    .rx_frame_done_i(rxd), .rx_frame_len_i(ln), .rx_tag_stripped_i(rxs),
    .rx_filter_pass_i(rxp), .stats_refresh_event_o(ev));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // ack and read data are fixed one cycle after the taking edge
  task automatic acc(input logic w, input logic s, input logic [8:0] a, input logic [31:0] d);
    @(negedge clk_i);
    {req, wr, io, addr, wdata} = {1'b1, w, s, a, d};
    @(negedge clk_i);
    {req, io} = 2'b00;
    k = ack;
    q = rdata;
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    acc(1'b0, 1'b0, a, '0);
    check(k, 1);
    check(q, exp);
  endtask
  // one frame on either side; event sampled two edges after the frame edge
  task automatic frame(input logic t, input logic [15:0] l, input logic g, input logic p);
    @(negedge clk_i);
    {txd, rxd, ln, txt, rxs, rxp} = {t, !t, l, g, g, p};
    @(negedge clk_i);
    {txd, rxd} = 2'b00;
    @(negedge clk_i);
    e = ev;
  endtask
  task automatic s_bins;
    logic [15:0] lens [9] = '{16'd63, 16'd64, 16'd65, 16'd127, 16'd128,
                              16'd60, 16'd124, 16'd123, 16'd64};
    logic [8:0] tg = 9'b000001110;
    logic [8:0] ps = 9'b011111111;
    gen = 1;
    foreach (lens[i])
    begin
      frame(1'b0, lens[i], tg[8-i], ps[8-i]);
      check(e, 0);
    end
    rd(PKO, 32'h8);
    rd(L64, 32'h3);
    rd(L65, 32'h3);
  endtask
  task automatic s_tx_mask;
    frame(1'b1, 16'd100, 1'b0, 1'b1);
    frame(1'b1, 16'd100, 1'b1, 1'b1);
    rd(TXO, 32'd204);
    gen = 0;
    frame(1'b0, 16'd64, 1'b0, 1'b1);
    {gen, mask} = 5'b10100;
    frame(1'b0, 16'd64, 1'b0, 1'b1);
    {gen, mask} = 5'b11001;
    frame(1'b1, 16'd100, 1'b0, 1'b1);
    frame(1'b0, 16'd100, 1'b0, 1'b1);
    mask = '0;
    rd(PKO, 32'ha);
    rd(L64, 32'h3);
    rd(L65, 32'h3);
    rd(TXO, 32'd204);
  endtask
  task automatic s_thresh_io;
    acc(1'b1, 1'b0, TXO, 32'h0000_bff6);
    check(k, 1);
    frame(1'b1, 16'd10, 1'b0, 1'b1);
    check(e, 1);
    rd(TXO, 32'h0000_c000);
    acc(1'b1, 1'b0, PKO, 32'hffff_ffff);
    frame(1'b0, 16'd200, 1'b0, 1'b1);
    rd(PKO, 32'h0);
    acc(1'b1, 1'b1, TXO, 32'h5);
    check(k, 0);
    rd(TXO, 32'h0000_c000);
    rd(9'h000, 32'h0);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #25000;
    n_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(negedge clk_i);
    rst_n_i = 1;
    rd(TXO, 32'h0);
    rd(PKO, 32'h0);
    rd(L64, 32'h0);
    rd(L65, 32'h0);
    s_bins();
    s_tx_mask();
    s_thresh_io();
    print_verdict();
  end
endmodule
`default_nettype wire

// ### verification/rmon_stats_sva.sv
// rmon_stats_sva: port-level checks of the statistics counter bank.
// assumes: bound onto rmon_stats_counters; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module rmon_stats_sva
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        reg_req_i,
  input wire logic        reg_io_space_i,
  input wire logic        reg_wr_i,
  input wire logic [8:0]  reg_addr_i,
  input wire logic        reg_ack_o,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        stats_global_enable_i,
  input wire logic [3:0]  rmon_counter_mask_i,
  input wire logic        tx_frame_done_i,
  input wire logic        rx_frame_done_i,
  input wire logic        stats_refresh_event_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic mem_rd;
  assign mem_rd = reg_req_i && !reg_io_space_i && !reg_wr_i;
  chk_ack_taken: assert property (reg_req_i && !reg_io_space_i |=> reg_ack_o)
    else $error("no ack after memory access");
  chk_io_no_ack: assert property (reg_req_i && reg_io_space_i |=> !reg_ack_o)
    else $error("ack after io access");
  chk_ack_cause: assert property (reg_ack_o |-> $past(reg_req_i && !reg_io_space_i))
    else $error("ack without request");
  chk_unmapped_zero: assert property (mem_rd && reg_addr_i == 9'h000 |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!mem_rd |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  chk_event_cause: assert property (stats_refresh_event_o |->
    $past(tx_frame_done_i || rx_frame_done_i, 2))
    else $error("event without frame");
  chk_event_enable: assert property (stats_refresh_event_o |->
    $past(stats_global_enable_i, 2))
    else $error("event while disabled");
  chk_event_mask: assert property (stats_refresh_event_o |->
    $past(rmon_counter_mask_i != 4'hf, 2))
    else $error("event with all counters masked");
  cover property (reg_ack_o);
  cover property (stats_refresh_event_o);
  cover property (mem_rd && reg_addr_i == 9'h000);
endmodule
bind rmon_stats_counters rmon_stats_sva chk_u (.clk_i, .rst_n_i, .reg_req_i, .reg_io_space_i,
  .reg_wr_i, .reg_addr_i, .reg_ack_o, .reg_rdata_o, .stats_global_enable_i,
  .rmon_counter_mask_i, .tx_frame_done_i, .rx_frame_done_i, .stats_refresh_event_o);
`default_nettype wire
